// [hdl/audio_rx_defines.vh]
// Constants for the serial audio input port with power sequencing.
// Assumes a 20 MHz APB clock that also serves as the system clock.
`ifndef AUDIO_RX_DEFINES_VH
`define AUDIO_RX_DEFINES_VH

// Printed register indexes; byte address is four times the index
`define IDX_FORMAT 6'd3
`define IDX_POWER 6'd4
`define IDX_STATUS 6'd5

`define FORMAT_RESET 8'h00
`define POWER_RESET 8'h00
`define FMT_FIELD_MSB 2
`define SOFT_PD_BIT 0

// Digital reset hold after power-up request, in system clock cycles
`define HOLD_CYCLES 11'd1024
`define HOLD_LAST 10'd1023
// Output ramp length in sample periods
`define RAMP_SAMPLES 14'd9334
// Allowed frame length drift in bit clocks
`define SYNC_TOL 8'd3

// Format kinds in a table entry
`define KIND_RJ 2'd0
`define KIND_I2S 2'd1
`define KIND_LJ 2'd2
// Word length codes in a table entry
`define LEN_16 2'd0
`define LEN_20 2'd1
`define LEN_24 2'd2

// Entry = {master, kind[1:0], len[1:0]}, entry 0 in the low bits
`define FMT_TABLE {5'h05, 5'h1a, 5'h04, 5'h00, 5'h01, 5'h02, 5'h06, 5'h0a}

// Master clock divider: 4 system clocks per bit, 64 bits per frame
`define MDIV_BCK_BIT 1
`define MDIV_WS_BIT 7

`endif

// [hdl/audio_serial_rx.v]
// Serial audio input port with power-on/off ramp and APB mode registers.
// Assumes pclk is the system clock; link pins arrive unsynchronised.
// Operation
// - Hold digital reset 1024 clocks after power-up.
// - Ramp outputs up over 9334 samples.
// - Pin low first, then ramp down 9334.
// - Soft power-down bit 0 of register 4.
// - Soft and pin power share ramping.
// - Pin power cycle resets mode registers too.
// - Soft power cycle keeps mode registers.
// - Sample data on bit clock rising edge.
// - Latch finished word on word-select edge.
// - Master drives both clocks, slave receives.
// - Master makes 64 fs bit, fs word.
// - Master only left-justified, 64 and 256.
// - Any word-select phase, but kept synchronous.
// - Drift over 3 bits halts, holds output.
// - Standard, I2S 16/20/24 bits; left-justified 24 bits.
// - Reset default 24-bit left-justified slave.
// - Samples are two's complement, MSB first.
// - I2S: select low left, high right.
// - Left-justified: select high left, low right.
// - Pin low powers down, defaults registers.
//
// The register offsets and the APB register port are this design's own decisions.
`include "audio_rx_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module audio_serial_rx #(
	parameter [39:0] FMT_TABLE = `FMT_TABLE
) (
	input wire pclk,
	input wire presetn,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire power_down_n,
	input wire serial_bit_clock_pin,
	output reg serial_bit_clock_drv,
	output reg serial_bit_clock_oe,
	input wire word_select_clock_pin,
	output reg word_select_clock_drv,
	output reg word_select_clock_oe,
	input wire serial_data_pin,
	output reg [23:0] left_headphone_out,
	output reg [23:0] right_headphone_out
);

	localparam [2:0] ST_OFF = 3'd0;
	localparam [2:0] ST_HOLD = 3'd1;
	localparam [2:0] ST_UP = 3'd2;
	localparam [2:0] ST_ON = 3'd3;
	localparam [2:0] ST_DOWN = 3'd4;

	reg [7:0] format_q;
	reg [7:0] power_q;
	reg [2:0] state_q;
	reg [9:0] hold_q;
	reg [13:0] ramp_q;
	reg [1:0] pd_sync_q;
	reg [2:0] bck_sync_q;
	reg [2:0] ws_sync_q;
	reg [1:0] dat_sync_q;
	reg [7:0] mdiv_q;
	reg [23:0] shift_q;
	reg [6:0] bitpos_q;
	reg [7:0] frame_bits_q;
	reg [7:0] prev_bits_q;
	reg prev_valid_q;
	reg sync_lost_q;
	reg [23:0] left_q;
	reg [23:0] right_q;

	wire pin_up = pd_sync_q[1];
	wire soft_pd = power_q[`SOFT_PD_BIT];
	// Either source asks for power-down; both share one ramp sequencer
	wire pd_req = ~pin_up | soft_pd;
	wire dig_clr = (state_q == ST_OFF) || (state_q == ST_HOLD);

	wire [2:0] fmt_sel = format_q[`FMT_FIELD_MSB:0];
	wire [39:0] ent_sh = FMT_TABLE >> (fmt_sel * 6'd5);
	wire is_master = ent_sh[4];
	// Master operation is restricted to left-justified framing
	wire [1:0] kind = is_master ? `KIND_LJ : ent_sh[3:2];
	wire [1:0] len_code = ent_sh[1:0];
	wire [6:0] word_len = (len_code == `LEN_16) ? 7'd16 : ((len_code == `LEN_20) ? 7'd20 : 7'd24);

	// APB slave, zero wait states
	wire setup = psel & ~penable;
	wire wr_ok = psel & penable & pready & pwrite;
	reg hit;
	reg [31:0] rd_mux;
	always @*
	begin
		hit = 1'b1;
		rd_mux = 32'h0000_0000;
		if (paddr[7:2] == `IDX_FORMAT)
			rd_mux = {24'h00_0000, format_q};
		else if (paddr[7:2] == `IDX_POWER)
			rd_mux = {24'h00_0000, power_q};
		else if (paddr[7:2] == `IDX_STATUS)
			rd_mux = {2'b00, ramp_q, 11'h000, is_master, sync_lost_q, state_q};
		else
			hit = 1'b0;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup & ~hit;
			if (setup)
				prdata <= (hit && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// Mode registers: pin power-down returns them to defaults, soft does not
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			format_q <= `FORMAT_RESET;
			power_q <= `POWER_RESET;
		end
		else if (!pin_up)
		begin
			format_q <= `FORMAT_RESET;
			power_q <= `POWER_RESET;
		end
		else if (wr_ok && hit)
		begin
			if (paddr[7:2] == `IDX_FORMAT)
				format_q <= pwdata[7:0];
			else if (paddr[7:2] == `IDX_POWER)
				power_q <= pwdata[7:0];
		end
	end

	// Power sequencer
	wire frame_tick;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= ST_OFF;
			hold_q <= 10'd0;
			ramp_q <= 14'd0;
		end
		else
		begin
			case (state_q)
				ST_OFF:
				begin
					hold_q <= 10'd0;
					ramp_q <= 14'd0;
					if (!pd_req)
						state_q <= ST_HOLD;
				end
				ST_HOLD:
				begin
					hold_q <= hold_q + 10'd1;
					if (pd_req)
						state_q <= ST_OFF;
					else if (hold_q == `HOLD_LAST)
						state_q <= ST_UP;
				end
				ST_UP:
				begin
					if (pd_req)
						state_q <= ST_DOWN;
					else if (ramp_q == `RAMP_SAMPLES)
						state_q <= ST_ON;
					else if (frame_tick)
						ramp_q <= ramp_q + 14'd1;
				end
				ST_ON:
				begin
					if (pd_req)
						state_q <= ST_DOWN;
				end
				ST_DOWN:
				begin
					if (!pd_req)
						state_q <= ST_UP;
					else if (ramp_q == 14'd0)
						state_q <= ST_OFF;
					else if (frame_tick)
						ramp_q <= ramp_q - 14'd1;
				end
				default:
				begin
					state_q <= ST_OFF;
				end
			endcase
		end
	end

	// Master clock divider: 256 system clocks per frame
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mdiv_q <= 8'h00;
		else if (dig_clr || !is_master)
			mdiv_q <= 8'h00;
		else
			mdiv_q <= mdiv_q + 8'h01;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			serial_bit_clock_drv <= 1'b0;
			serial_bit_clock_oe <= 1'b0;
			word_select_clock_drv <= 1'b0;
			word_select_clock_oe <= 1'b0;
		end
		else
		begin
			serial_bit_clock_oe <= is_master;
			word_select_clock_oe <= is_master;
			serial_bit_clock_drv <= is_master & mdiv_q[`MDIV_BCK_BIT];
			// Left half first, select high for left
			word_select_clock_drv <= is_master & ~mdiv_q[`MDIV_WS_BIT];
		end
	end

	// In master mode our own clocks go through the same synchroniser as data
	wire bck_lvl = is_master ? serial_bit_clock_drv : serial_bit_clock_pin;
	wire ws_lvl = is_master ? word_select_clock_drv : word_select_clock_pin;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pd_sync_q <= 2'b00;
			bck_sync_q <= 3'b000;
			ws_sync_q <= 3'b000;
			dat_sync_q <= 2'b00;
		end
		else
		begin
			pd_sync_q <= {pd_sync_q[0], power_down_n};
			bck_sync_q <= {bck_sync_q[1:0], bck_lvl};
			ws_sync_q <= {ws_sync_q[1:0], ws_lvl};
			dat_sync_q <= {dat_sync_q[0], serial_data_pin};
		end
	end

	// Slave timing relies on the far end keeping its clocks in ratio
	wire bck_rise = bck_sync_q[1] & ~bck_sync_q[2];
	wire ws_edge = ws_sync_q[1] ^ ws_sync_q[2];
	wire ws_rise = ws_sync_q[1] & ~ws_sync_q[2];
	wire ws_prev = ws_sync_q[2];
	assign frame_tick = ws_rise & ~sync_lost_q;

	// Which bit positions of a half frame feed the word
	wire [6:0] first_bit = (kind == `KIND_I2S) ? 7'd1 : 7'd0;
	wire [6:0] end_bit = first_bit + word_len;
	wire take_bit = (kind == `KIND_RJ) || ((bitpos_q >= first_bit) && (bitpos_q < end_bit));

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			shift_q <= 24'h00_0000;
			bitpos_q <= 7'd0;
		end
		else if (dig_clr)
		begin
			shift_q <= 24'h00_0000;
			bitpos_q <= 7'd0;
		end
		else if (ws_edge)
		begin
			bitpos_q <= 7'd0;
		end
		else if (bck_rise)
		begin
			// MSB first: older bits move up
			if (take_bit)
				shift_q <= {shift_q[22:0], dat_sync_q[1]};
			if (bitpos_q != 7'h7f)
				bitpos_q <= bitpos_q + 7'd1;
		end
	end

	// Word aligned to 24 bits; the low bits hold the last word_len bits
	wire [23:0] word = (len_code == `LEN_16) ? {shift_q[15:0], 8'h00} :
		((len_code == `LEN_20) ? {shift_q[19:0], 4'h0} : shift_q);
	// Channel of the half frame that just ended
	wire was_left = (kind == `KIND_I2S) ? ~ws_prev : ws_prev;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			left_q <= 24'h00_0000;
			right_q <= 24'h00_0000;
		end
		else if (dig_clr)
		begin
			left_q <= 24'h00_0000;
			right_q <= 24'h00_0000;
		end
		else if (ws_edge && !sync_lost_q)
		begin
			if (was_left)
				left_q <= word;
			else
				right_q <= word;
		end
	end

	// Frame length watch: bit clocks between select rising edges
	wire [7:0] diff = (frame_bits_q > prev_bits_q) ? frame_bits_q - prev_bits_q : prev_bits_q - frame_bits_q;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			frame_bits_q <= 8'h00;
			prev_bits_q <= 8'h00;
			prev_valid_q <= 1'b0;
			sync_lost_q <= 1'b0;
		end
		else if (dig_clr)
		begin
			frame_bits_q <= 8'h00;
			prev_bits_q <= 8'h00;
			prev_valid_q <= 1'b0;
			sync_lost_q <= 1'b0;
		end
		else if (ws_rise)
		begin
			frame_bits_q <= bck_rise ? 8'h01 : 8'h00;
			prev_bits_q <= frame_bits_q;
			prev_valid_q <= 1'b1;
			// Decided at every frame end, so a halt starts within one sample
			if (prev_valid_q)
				sync_lost_q <= diff > `SYNC_TOL;
		end
		else if (bck_rise && frame_bits_q != 8'hff)
		begin
			frame_bits_q <= frame_bits_q + 8'h01;
		end
	end

	// Ramp gain is ramp_q / RAMP_SAMPLES; exact unity once the ramp ends
	wire signed [38:0] ramp_div = $signed({25'd0, `RAMP_SAMPLES});
	wire signed [38:0] gain = $signed({25'd0, ramp_q});
	wire signed [38:0] prod_l = $signed({{15{left_q[23]}}, left_q}) * gain;
	wire signed [38:0] prod_r = $signed({{15{right_q[23]}}, right_q}) * gain;
	wire signed [38:0] quot_l = prod_l / ramp_div;
	wire signed [38:0] quot_r = prod_r / ramp_div;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			left_headphone_out <= 24'h00_0000;
			right_headphone_out <= 24'h00_0000;
		end
		else if (state_q == ST_OFF || state_q == ST_HOLD)
		begin
			left_headphone_out <= 24'h00_0000;
			right_headphone_out <= 24'h00_0000;
		end
		else if (!sync_lost_q)
		begin
			left_headphone_out <= quot_l[23:0];
			right_headphone_out <= quot_r[23:0];
		end
	end

endmodule // audio_serial_rx

`default_nettype wire

// [verification/audio_rx_properties.sv]
// Checker for the serial audio input port: bus handshake and master clocks.
// Assumes it is bound to audio_serial_rx and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module audio_rx_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic power_down_n,
	input wire logic serial_bit_clock_drv,
	input wire logic serial_bit_clock_oe,
	input wire logic word_select_clock_drv,
	input wire logic word_select_clock_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_setup_ready; psel && !penable |=> pready; endproperty
	property p_ready_pulse; pready |=> !pready; endproperty
	property p_err_ready; pslverr |-> pready; endproperty
	// Read data is loaded only at a setup edge, so it stands through the access cycle
	property p_rdata_hold; !($past(psel) && !$past(penable)) |-> $stable(prdata); endproperty
	property p_oe_pair; serial_bit_clock_oe == word_select_clock_oe; endproperty
	property p_slave_idle; !serial_bit_clock_oe |-> !serial_bit_clock_drv && !word_select_clock_drv; endproperty
	// A switch back to slave may cut a bit short, so a dropped enable excuses it
	property p_bck_high;
		$rose(serial_bit_clock_drv) |=> (serial_bit_clock_drv ##1 !serial_bit_clock_drv) or !serial_bit_clock_oe;
	endproperty
	property p_bck_low;
		$fell(serial_bit_clock_drv) && serial_bit_clock_oe |=>
			(!serial_bit_clock_drv ##1 serial_bit_clock_drv) or !serial_bit_clock_oe or ##1 !serial_bit_clock_oe;
	endproperty
	property p_ws_on_low;
		$changed(word_select_clock_drv) && $past(word_select_clock_oe) && word_select_clock_oe |-> !serial_bit_clock_drv;
	endproperty
	property p_pin_defaults; !power_down_n [*6] |-> !serial_bit_clock_oe; endproperty
	a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved in access");
	a_oe_pair: assert property (p_oe_pair) else $error("clock enables differ");
	a_slave_idle: assert property (p_slave_idle) else $error("clock driven in slave mode");
	a_bck_high: assert property (p_bck_high) else $error("bit clock high time wrong");
	a_bck_low: assert property (p_bck_low) else $error("bit clock low time wrong");
	a_ws_on_low: assert property (p_ws_on_low) else $error("word select moved with bit clock high");
	a_pin_defaults: assert property (p_pin_defaults) else $error("master kept with pin low");
	c_master: cover property ($rose(serial_bit_clock_oe));
	c_err: cover property (pslverr);
	c_pin: cover property ($fell(power_down_n));
endmodule // audio_rx_checker
bind audio_serial_rx audio_rx_checker i_chk (.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
	.power_down_n, .serial_bit_clock_drv, .serial_bit_clock_oe, .word_select_clock_drv, .word_select_clock_oe);
`default_nettype wire

// [verification/audio_link_model.sv]
// Far-end audio source: left-justified or I2S frames of 48 bit clocks per sample.
// Assumes the device listens in slave mode; clocks run freely like a decoder.
`timescale 1ns/1ns
`default_nettype none
module audio_link_model (
	input wire logic [23:0] left_word,
	input wire logic [23:0] right_word,
	input wire logic i2s,
	output logic serial_bit_clock,
	output logic ws,
	output logic dat
);
	int i;
	logic [23:0] w;
	initial
	begin
		serial_bit_clock = 1'b0;
		ws = 1'b0;
		dat = 1'b0;
		// Clocks are not derived from pclk: that derivation is only preferred
		#13;
		forever
			for (i = 0; i < 48; i++)
			begin
				#200 serial_bit_clock = 1'b0;
				w = (i < 24) ? left_word : right_word;
				ws = (i < 24) ^ i2s;
				// I2S puts the MSB one bit after the select edge
				dat = (i2s && i % 24 == 0) ? 1'b0 : w[23 - i % 24 + i2s];
				// 400 ns bit gives 384 system clocks per frame
				#200 serial_bit_clock = 1'b1;
			end
	end
endmodule // audio_link_model
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the serial audio input port.
// Assumes a 20 MHz pclk and a free-running far-end source.
`timescale 1ns/1ns
`default_nettype none
`include "audio_rx_defines.vh"
module testbench;
	localparam logic [7:0] A_FMT = 8'(`IDX_FORMAT) << 2;
	localparam logic [7:0] A_PWR = 8'(`IDX_POWER) << 2;
	localparam logic [7:0] A_STS = 8'(`IDX_STATUS) << 2;
	logic pclk, presetn, psel, penable, pwrite, power_down_n, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic bck_drv, bck_oe, ws_drv, ws_oe, m_bck, m_ws, serial_bit_clock, ws, dat, i2s_mode;
	logic [23:0] lout, rout, left_w, right_w;
	int n_mismatch = 0, tests_run = 0, cyc = 0;
	logic [41:0] rows [6] = '{{A_FMT, 1'b0, 32'h0, 1'b0}, {A_PWR, 1'b0, 32'h0, 1'b0},
		{8'h04, 1'b0, 32'h0, 1'b1}, {A_FMT, 1'b1, 32'h6, 1'b0}, {A_FMT, 1'b0, 32'h6, 1'b0},
		{A_STS, 1'b1, 32'hff, 1'b0}};
	assign serial_bit_clock = bck_oe ? bck_drv : m_bck;
	assign ws = ws_oe ? ws_drv : m_ws;
	audio_link_model i_far (.left_word(left_w), .right_word(right_w), .i2s(i2s_mode), .serial_bit_clock(m_bck), .ws(m_ws),
		.dat(dat));
	audio_serial_rx i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.power_down_n(power_down_n), .serial_bit_clock_pin(serial_bit_clock), .serial_bit_clock_drv(bck_drv),
		.serial_bit_clock_oe(bck_oe), .word_select_clock_pin(ws), .word_select_clock_drv(ws_drv),
		.word_select_clock_oe(ws_oe), .serial_data_pin(dat), .left_headphone_out(lout),
		.right_headphone_out(rout));
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic st(input logic [2:0] s);
		apb(A_STS, 1'b0, 32'h0);
		chk(r & 32'h7, {29'h0, s});
	endtask
	task automatic results();
		$display("mismatches %0d of %0d checks", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_mismatch++;
			results();
		end
	end
	initial
	begin
		{presetn, psel, penable, pwrite, power_down_n, paddr, pwdata} = '0;
		left_w = 24'h7fffff;
		right_w = 24'h800000;
		i2s_mode = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (20000) @(posedge pclk);
		power_down_n <= 1'b1;
		repeat (900) @(posedge pclk);
		st(3'h1);
		repeat (150) @(posedge pclk);
		st(3'h2);
		$display("hold test done");
		foreach (rows[i])
		begin
			apb(rows[i][41:34], rows[i][33], rows[i][32:1]);
			if (!rows[i][33])
				chk(r, rows[i][32:1]);
			chk({31'h0, e}, {31'h0, rows[i][0]});
		end
		repeat (600) @(posedge pclk);
		apb(A_STS, 1'b0, 32'h0);
		chk({31'h0, r[4]}, 32'h1);
		apb(A_FMT, 1'b1, 32'h0);
		$display("register test done");
		repeat (3000) @(posedge pclk);
		chk({31'h0, $signed(lout) > 0}, 32'h1);
		chk({31'h0, $signed(rout) < 0}, 32'h1);
		apb(A_STS, 1'b0, 32'h0);
		chk({31'h0, r[29:16] > 0 && r[29:16] < `RAMP_SAMPLES}, 32'h1);
		chk({31'h0, r[3]}, 32'h0);
		$display("ramp test done");
		i2s_mode <= 1'b1;
		apb(A_FMT, 1'b1, 32'h5);
		repeat (3000) @(posedge pclk);
		chk({31'h0, $signed(lout) > 0}, 32'h1);
		chk({31'h0, $signed(rout) < 0}, 32'h1);
		$display("i2s test done");
		apb(A_FMT, 1'b1, 32'h7);
		apb(A_PWR, 1'b1, 32'h1);
		st(3'h4);
		repeat (15400) @(posedge pclk);
		st(3'h0);
		chk({8'h0, lout}, 32'h0);
		apb(A_FMT, 1'b0, 32'h0);
		chk(r, 32'h7);
		apb(A_PWR, 1'b1, 32'h0);
		st(3'h1);
		$display("soft power test done");
		power_down_n <= 1'b0;
		repeat (8) @(posedge pclk);
		apb(A_FMT, 1'b0, 32'h0);
		chk(r, 32'h0);
		$display("pin power test done");
		results();
	end
endmodule // testbench
`default_nettype wire
